// [design/csd_core.sv]
/*
 csd_core: execution of the two compare-skip instructions and decimal
 adjust, with an AXI4-Lite slave for working register, flags, bank
 select and configuration.
 assumes: fetch pipeline presents a word in Q1, synchronous data memory
 answers one clock after the Q2 request, all inputs on clk.
*/
// Contract
// - greater compare decoded from 0110 010a
// - skip when byte exceeds working register
// - less compare decoded from 0110 000a
// - skip when byte below working register
// - skip discards fetched word, two cycles
// - two-word victim gives three cycles total
// - skipped cycles do nothing in every phase
// - a=0 access bank, a=1 bank select
// - extended set, a=0, f<=95: indexed
// - decimal adjust decoded from 0007, only carry
// - high nibble plus six plus digit carry
// - decimal adjust completes in one cycle
`timescale 1ns/1ps
module csd_core (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  ce,
	// axi4-lite slave
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// fetch pipeline
	input  wire logic [15:0]           instr_word,
	input  wire logic                  instr_valid,
	input  wire logic                  next_two_word,
	input  wire logic [11:0]           index_base,
	// data memory
	output csd_pkg::csd_mem_req_t      mem_req,
	input  wire logic [7:0]            mem_rdata,
	// pipeline status
	output csd_pkg::csd_phase_t        phase,
	output logic                       squash
);
	import csd_pkg::*;

	// decode helpers, shared by decode and the checks
	function automatic logic is_gt(input logic [15:0] w);
		is_gt = (w[15:9] == CSD_OPC_GT);
	endfunction
	function automatic logic is_lt(input logic [15:0] w);
		is_lt = (w[15:9] == CSD_OPC_LT);
	endfunction

	logic [7:0]  working_register;     // accumulator
	csd_flags_t  flags;                // carry and digit_carry_flag
	logic [3:0]  bank_select_register; // general purpose bank number
	logic        ext_en;               // extended instruction set enable
	logic [7:0]  skips;                // count of skips taken
	csd_op_t     op;                   // operation of this instruction cycle
	logic [7:0]  operand;              // working register taken in Q2 for adjust
	logic        cond;                 // skip condition, valid in Q4
	logic [7:0]  adj_result;           // adjusted value, valid in Q4
	logic        adj_ovf;              // high nibble overflow, valid in Q4
	logic [1:0]  skip_cnt;             // instruction cycles still to discard
	// bus side state
	logic        aw_held;              // write address taken
	logic        w_held;               // write data taken
	logic [7:0]  aw_addr;              // held write address
	logic [31:0] w_data;               // held write data
	logic [3:0]  w_strb;               // held byte enables

	wire         take_word;   // Q1 with a live instruction and no squash
	wire csd_op_t dec_op;     // decode of the presented word
	wire [11:0]  opnd_addr;   // resolved file address
	wire         opnd_lit;    // literal offset mode in use
	wire [7:0]   adj_value;   // decimal adjust result
	wire         adj_carry;   // decimal adjust overflow
	wire         gt_hit;      // byte strictly above working register
	wire         lt_hit;      // byte strictly below working register
	wire         wr_fire;     // both write halves present
	wire         wr_work;     // software write to working register
	wire         wr_status;   // software write to flags
	wire         wr_bank;     // software write to bank select
	wire         wr_cfg;      // software write to configuration
	wire         wr_mapped;   // write address decodes
	wire         rd_fire;     // read address accepted
	wire         rd_mapped;   // read address decodes
	wire [31:0]  rd_mux;      // selected read data
	wire         hw_work_we;  // decimal adjust writes back in Q4
	wire         skip_now;    // compare hit at the Q4 edge
	assign squash    = (skip_cnt != CSD_RST_SKIP);
	// a word presented while a skip runs is discarded, not decoded
	assign take_word = ce && (phase == CSD_Q1) && instr_valid && !squash;
	assign dec_op    = is_gt(instr_word) ? CSD_OP_GT :
	                   is_lt(instr_word) ? CSD_OP_LT :
	                   (instr_word == CSD_OPC_ADJ) ? CSD_OP_ADJ : CSD_OP_NONE;
	// unsigned compare of byte against the working register
	assign gt_hit     = (mem_rdata > working_register);
	assign lt_hit     = (mem_rdata < working_register);
	assign hw_work_we = ce && (phase == CSD_Q4) && (op == CSD_OP_ADJ);
	assign skip_now   = ce && (phase == CSD_Q4) && (op == CSD_OP_GT || op == CSD_OP_LT) && cond;
	csd_opnd_addr u_addr (
		.f_addr               (instr_word[7:0]),
		.a_bit                (instr_word[8]),
		.ext_en               (ext_en),
		.bank_select_register (bank_select_register),
		.index_base           (index_base),
		.addr                 (opnd_addr),
		.lit_mode             (opnd_lit)
	);
	csd_dec_adjust u_adj (
		.acc_in    (operand),
		.flags_in  (flags),
		.acc_out   (adj_value),
		.carry_set (adj_carry)
	);
	// quarter phase sequencer, free running while enabled
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			phase <= CSD_Q1;
		else if (ce)
		begin
			case (phase)
				CSD_Q1:  phase <= CSD_Q2;
				CSD_Q2:  phase <= CSD_Q3;
				CSD_Q3:  phase <= CSD_Q4;
				CSD_Q4:  phase <= CSD_Q1;
				default: phase <= CSD_Q1;
			endcase
		end
	end
	// Q1 decode; operation held for the rest of the cycle
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			op <= CSD_OP_NONE;
		else if (ce && phase == CSD_Q1)
			op <= take_word ? dec_op : CSD_OP_NONE;
	end
	// Q2 read: file byte for a compare, issued from the Q1 edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			mem_req <= '0;
		else if (ce)
		begin
			mem_req.rd   <= take_word && (dec_op == CSD_OP_GT || dec_op == CSD_OP_LT);
			mem_req.addr <= take_word ? opnd_addr : mem_req.addr;
		end
	end
	// Q2 operand: working register for adjust; Q3 compare outcome taken from the memory byte
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			operand <= CSD_RST_WORK;
			cond    <= 1'b0;
		end
		else if (ce && phase == CSD_Q2 && op == CSD_OP_ADJ)
			operand <= working_register;
		else if (ce && phase == CSD_Q3)
			cond <= (op == CSD_OP_GT) ? gt_hit : (op == CSD_OP_LT) ? lt_hit : 1'b0;
	end
	// Q3 process for decimal adjust
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			adj_result <= CSD_RST_WORK;
			adj_ovf    <= 1'b0;
		end
		else if (ce && phase == CSD_Q3 && op == CSD_OP_ADJ)
		begin
			adj_result <= adj_value;
			adj_ovf    <= adj_carry;
		end
	end
	// skip length: one discarded cycle, two when the victim is two words
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			skip_cnt <= CSD_RST_SKIP;
		else if (skip_now)
			skip_cnt <= next_two_word ? CSD_SKIP_TWO : CSD_SKIP_ONE;
		else if (ce && phase == CSD_Q4 && squash)
			skip_cnt <= skip_cnt - 2'h1;
	end

	// skip statistics for software
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			skips <= 8'h00;
		else if (skip_now)
			skips <= skips + 8'h01;
	end
	// bus write decode
	assign wr_fire   = aw_held && w_held && !s_axi_bvalid;
	assign wr_work   = wr_fire && (aw_addr == CSD_OFS_WORK) && w_strb[0];
	assign wr_status = wr_fire && (aw_addr == CSD_OFS_STATUS) && w_strb[0];
	assign wr_bank   = wr_fire && (aw_addr == CSD_OFS_BANK) && w_strb[0];
	assign wr_cfg    = wr_fire && (aw_addr == CSD_OFS_CFG) && w_strb[0];
	assign wr_mapped = (aw_addr == CSD_OFS_WORK) || (aw_addr == CSD_OFS_STATUS) ||
	                   (aw_addr == CSD_OFS_BANK) || (aw_addr == CSD_OFS_CFG) ||
	                   (aw_addr == CSD_OFS_SKIPS);
	// working register: the instruction write-back wins over software
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			working_register <= CSD_RST_WORK;
		else if (hw_work_we)
			working_register <= adj_result;
		else if (wr_work)
			working_register <= w_data[7:0];
	end
	// flags: only carry is changed by the instructions, set beats clear
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			flags <= '0;
		else
		begin
			if (wr_status)
				flags <= {w_data[CSD_ST_DIGIT], w_data[CSD_ST_CARRY]};
			if (hw_work_we && adj_ovf)
				flags.carry <= 1'b1;
		end
	end
	// configuration registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bank_select_register <= CSD_RST_BANK;
			ext_en               <= 1'b0;
		end
		else
		begin
			if (wr_bank)
				bank_select_register <= w_data[3:0];
			if (wr_cfg)
				ext_en <= w_data[CSD_CFG_EXT];
		end
	end

	// write channel capture, either order, one write in flight
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CSD_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? CSD_RESP_OKAY : CSD_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read channel: registered data, unmapped reads zero with an error
	assign rd_fire   = s_axi_arvalid && s_axi_arready;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_mapped = (s_axi_araddr == CSD_OFS_WORK) || (s_axi_araddr == CSD_OFS_STATUS) ||
	                   (s_axi_araddr == CSD_OFS_BANK) || (s_axi_araddr == CSD_OFS_CFG) ||
	                   (s_axi_araddr == CSD_OFS_SKIPS);
	assign rd_mux    = (s_axi_araddr == CSD_OFS_WORK)   ? {24'h0, working_register} :
	                   (s_axi_araddr == CSD_OFS_STATUS) ? {30'h0, flags} :
	                   (s_axi_araddr == CSD_OFS_BANK)   ? {28'h0, bank_select_register} :
	                   (s_axi_araddr == CSD_OFS_CFG)    ? {31'h0, ext_en} :
	                   (s_axi_araddr == CSD_OFS_SKIPS)  ? {24'h0, skips} : 32'h0000_0000;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= CSD_RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_mapped ? CSD_RESP_OKAY : CSD_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// checks
	gt_decode_a: assert property (@(posedge clk) disable iff (!nrst)
		(take_word && instr_word[15:9] == CSD_OPC_GT) |=> (op == CSD_OP_GT))
		else $error("greater compare not decoded");
	lt_decode_a: assert property (@(posedge clk) disable iff (!nrst)
		(take_word && instr_word[15:9] == CSD_OPC_LT) |=> (op == CSD_OP_LT))
		else $error("less compare not decoded");
	gt_skip_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && phase == CSD_Q3 && op == CSD_OP_GT) |=> (cond == ($past(mem_rdata) > $past(working_register))))
		else $error("greater compare outcome wrong");
	lt_skip_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && phase == CSD_Q3 && op == CSD_OP_LT) |=> (cond == ($past(mem_rdata) < $past(working_register))))
		else $error("less compare outcome wrong");
	skip_one_a: assert property (@(posedge clk) disable iff (!nrst)
		(skip_now && !next_two_word) |=> (skip_cnt == 2'h1))
		else $error("single skip length wrong");
	skip_two_a: assert property (@(posedge clk) disable iff (!nrst)
		(skip_now && next_two_word) |=> (skip_cnt == 2'h2) ##0 (squash [*4]))
		else $error("double skip length wrong");
	skip_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		(squash && phase == CSD_Q1 && ce) |=> (!mem_req.rd && op == CSD_OP_NONE))
		else $error("skipped cycle did work");
	bank_addr_a: assert property (@(posedge clk) disable iff (!nrst)
		(take_word && is_gt(instr_word) && instr_word[8])
		|=> (mem_req.rd && mem_req.addr == {$past(bank_select_register), $past(instr_word[7:0])}))
		else $error("banked address wrong");
	lit_addr_a: assert property (@(posedge clk) disable iff (!nrst)
		(take_word && opnd_lit && is_lt(instr_word))
		|=> (mem_req.addr == $past(index_base) + {4'h0, $past(instr_word[7:0])}))
		else $error("indexed address wrong");
	adj_cycle_a: assert property (@(posedge clk) disable iff (!nrst)
		(take_word && instr_word == CSD_OPC_ADJ && ce) ##1 ce [*3]
		|=> (working_register == $past(adj_result)))
		else $error("adjust not written in Q4");
	adj_carry_a: assert property (@(posedge clk) disable iff (!nrst)
		(hw_work_we && adj_ovf) |=> flags.carry)
		else $error("adjust carry not set");
endmodule

// [design/csd_pkg.sv]
/*
 csd_pkg: shared constants, encodings and carrier types for the
 compare-skip / decimal-adjust execution block.
 assumes: 32-bit AXI4-Lite register bus, 12-bit banked data addresses.
*/
package csd_pkg;
	// register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] CSD_OFS_WORK   = 8'h00; // working register
	localparam logic [7:0] CSD_OFS_STATUS = 8'h04; // carry bit0, digit carry bit1
	localparam logic [7:0] CSD_OFS_BANK   = 8'h08; // bank select register
	localparam logic [7:0] CSD_OFS_CFG    = 8'h0C; // bit0 extended set enable
	localparam logic [7:0] CSD_OFS_SKIPS  = 8'h10; // skip counter, read only
	// field positions
	localparam int CSD_ST_CARRY = 0;
	localparam int CSD_ST_DIGIT = 1;
	localparam int CSD_CFG_EXT  = 0;
	// reset values
	localparam logic [7:0] CSD_RST_WORK = 8'h00;
	localparam logic [3:0] CSD_RST_BANK = 4'h0;
	localparam logic [1:0] CSD_RST_SKIP = 2'h0;
	// instruction encodings
	localparam logic [6:0]  CSD_OPC_GT  = 7'h32; // upper byte 0110 010a
	localparam logic [6:0]  CSD_OPC_LT  = 7'h30; // upper byte 0110 000a
	localparam logic [15:0] CSD_OPC_ADJ = 16'h0007;
	// addressing
	localparam logic [7:0] CSD_LIT_MAX      = 8'h5F; // literal-offset window top
	localparam logic [7:0] CSD_ACCESS_SPLIT = 8'h80; // low/high half of access bank
	localparam logic [3:0] CSD_ACCESS_HI    = 4'hF;  // bank of the upper access half
	localparam logic [3:0] CSD_ACCESS_LO    = 4'h0;  // bank of the lower access half
	// decimal adjust constants
	localparam logic [4:0] CSD_BCD_MAX = 5'h09;
	localparam logic [4:0] CSD_BCD_ADJ = 5'h06;
	// skip lengths in instruction cycles
	localparam logic [1:0] CSD_SKIP_ONE = 2'h1;
	localparam logic [1:0] CSD_SKIP_TWO = 2'h2;
	// bus answers
	localparam logic [1:0] CSD_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CSD_RESP_SLVERR = 2'h2;

	// quarter phases, gray order along the cycle
	typedef enum logic [1:0] {
		CSD_Q1 = 2'b00,
		CSD_Q2 = 2'b01,
		CSD_Q3 = 2'b11,
		CSD_Q4 = 2'b10
	} csd_phase_t;

	// decoded operation
	typedef enum logic [1:0] {
		CSD_OP_NONE = 2'b00,
		CSD_OP_GT   = 2'b01,
		CSD_OP_LT   = 2'b11,
		CSD_OP_ADJ  = 2'b10
	} csd_op_t;

	// data memory read request
	typedef struct packed {
		logic        rd;
		logic [11:0] addr;
	} csd_mem_req_t;

	// arithmetic flags touched by decimal adjust
	typedef struct packed {
		logic digit_carry_flag;
		logic carry;
	} csd_flags_t;
endpackage

// [design/csd_opnd_addr.sv]
/*
 csd_opnd_addr: forms the 12-bit data memory address of a file operand.
 assumes: purely combinational, inputs from the core clock domain.
*/
`timescale 1ns/1ps
module csd_opnd_addr (
	input  wire logic [7:0]  f_addr,
	input  wire logic        a_bit,
	input  wire logic        ext_en,
	input  wire logic [3:0]  bank_select_register,
	input  wire logic [11:0] index_base,
	output logic      [11:0] addr,
	output logic             lit_mode
);
	import csd_pkg::*;

	wire [11:0] bank_addr;   // banked general purpose address
	wire [11:0] access_addr; // fixed access bank address
	wire [11:0] index_addr;  // literal offset from index base

	// literal offset only for a=0 low window with extended set on
	assign lit_mode    = ext_en && !a_bit && (f_addr <= CSD_LIT_MAX);
	assign bank_addr   = {bank_select_register, f_addr};
	// access bank splits into the bottom of bank 0 and the top of the last bank
	assign access_addr = (f_addr < CSD_ACCESS_SPLIT) ? {CSD_ACCESS_LO, f_addr}
	                                                 : {CSD_ACCESS_HI, f_addr};
	assign index_addr  = index_base + {4'h0, f_addr};
	assign addr        = lit_mode ? index_addr : (a_bit ? bank_addr : access_addr);
endmodule

// [design/csd_dec_adjust.sv]
/*
 csd_dec_adjust: packed BCD correction of the working register.
 assumes: purely combinational; caller registers the result.
*/
`timescale 1ns/1ps
module csd_dec_adjust (
	input  wire logic [7:0]        acc_in,
	input  wire csd_pkg::csd_flags_t flags_in,
	output logic      [7:0]        acc_out,
	output logic                   carry_set
);
	import csd_pkg::*;

	wire [4:0] lo_sum;  // low nibble, widened
	wire [4:0] lo_fix;  // low nibble after correction
	wire [4:0] hi_base; // high nibble plus digit carry
	wire [4:0] hi_fix;  // high nibble after correction

	assign lo_sum  = {1'b0, acc_in[3:0]};
	// low digit corrected when out of range or after a digit carry
	assign lo_fix  = ((lo_sum > CSD_BCD_MAX) || flags_in.digit_carry_flag) ? lo_sum + CSD_BCD_ADJ : lo_sum;
	assign hi_base = {1'b0, acc_in[7:4]} + {4'h0, flags_in.digit_carry_flag};
	assign hi_fix  = ((hi_base > CSD_BCD_MAX) || flags_in.carry) ? hi_base + CSD_BCD_ADJ : hi_base;
	// only four bits survive in each nibble, high nibble overflow becomes carry
	assign acc_out   = {hi_fix[3:0], lo_fix[3:0]};
	assign carry_set = hi_fix[4];
endmodule

// [dv/csd_mem_model.sv]
/*
 csd_mem_model: banked data memory on the far side of the compare path.
 assumes: one-clock synchronous read started by mem_req.rd; the bench pokes mem.
*/
`timescale 1ns/1ps
module csd_mem_model (
	input  wire logic                 clk,
	input  wire csd_pkg::csd_mem_req_t mem_req,
	output logic [7:0]                mem_rdata
);
	import csd_pkg::*;
	logic [7:0] mem [4096]; // byte store, filled by the bench
	initial mem_rdata = 8'h00;
	// data is valid only in the clock after a request; otherwise it toggles,
	// so a late or early sample by the core reads garbage instead of luck
	always @(posedge clk)
		mem_rdata <= mem_req.rd ? mem[mem_req.addr] : ~mem_rdata;
endmodule

// [dv/tb.sv]
/*
 tb: self-checking bench for csd_core: bus registers, compare-skip and decimal adjust.
 assumes: csd_pkg compiled first, csd_mem_model as the data memory.
*/
`timescale 1ns/1ps
module tb;
	import csd_pkg::*;
	logic        clk, nrst, ce, instr_valid, next_two_word, squash;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ta, tw;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, mem_rdata, f, w, b;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0]  s_axi_wstrb, bk;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] instr_word;
	logic [11:0] index_base, ga, xa;
	logic [8:0]  xd;
	logic        a, gt, two, ext, c, dcf, hit;
	csd_mem_req_t mem_req;
	csd_phase_t   phase, pv;
	int          errors, cmp_count, seed, n, rdn, sq, skips;

	csd_core i_dut (.clk, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .instr_word, .instr_valid, .next_two_word, .index_base, .mem_req, .mem_rdata,
		.phase, .squash);
	csd_mem_model i_mem (.clk, .mem_req, .mem_rdata);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] ad, input logic [31:0] d);
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (((s_axi_awvalid & !ta) | (s_axi_wvalid & !tw)) && ++n < 64);
		do @(negedge clk); while (!s_axi_bvalid && ++n < 64);
		if (!s_axi_bvalid) errors++;
		rsp = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [7:0] ad);
		n = 0;
		@(posedge clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge clk); while (!s_axi_arready && ++n < 64);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk); while (!s_axi_rvalid && ++n < 64);
		if (!s_axi_rvalid) errors++;
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask

	// present one word in Q1, then watch memory reads and squashed cycles
	task issue(input logic [15:0] iw, input logic tw2);
		rdn = 0;
		sq = 0;
		do @(negedge clk); while (phase !== CSD_Q4);
		@(posedge clk);
		instr_word <= iw;
		instr_valid <= 1'b1;
		next_two_word <= tw2;
		@(posedge clk);
		instr_valid <= 1'b0;
		instr_word <= 16'(unsigned'($random(seed)));
		repeat (15)
		begin
			@(negedge clk);
			if (mem_req.rd === 1'b1)
			begin
				rdn++;
				ga = mem_req.addr;
			end
			if (squash === 1'b1) sq++;
		end
		next_two_word <= 1'b0;
	endtask

	// operand address expected from bank bit, bank select and extended mode
	function logic [11:0] exp_addr(input logic [7:0] fa, input logic ab, input logic ex,
		input logic [3:0] bs, input logic [11:0] ib);
		if (!ab && ex && fa <= CSD_LIT_MAX) return ib + {4'h0, fa};
		if (ab) return {bs, fa};
		return {(fa < CSD_ACCESS_SPLIT) ? CSD_ACCESS_LO : CSD_ACCESS_HI, fa};
	endfunction

	// packed bcd correction: {carry, working register}
	function logic [8:0] exp_adjust(input logic [7:0] wv, input logic cv, input logic dv);
		logic [4:0] lo, hi;
		lo = {1'b0, wv[3:0]};
		hi = {1'b0, wv[7:4]} + 5'(dv);
		if (lo > CSD_BCD_MAX || dv) lo = lo + CSD_BCD_ADJ;
		if (hi > CSD_BCD_MAX || cv) hi = hi + CSD_BCD_ADJ;
		return {cv | hi[4], hi[3:0], lo[3:0]};
	endfunction

	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog: the whole run needs a few thousand cycles
	initial
	begin
		#400000;
		errors++;
		wrap_up();
	end

	initial
	begin
		seed = 32'hba97;
		{nrst, instr_valid, next_two_word, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{errors, cmp_count, skips} = '0;
		ce = 1'b1;
		s_axi_wstrb = 4'hF;
		instr_word = 16'h0000;
		index_base = 12'h000;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		// reset values, then an unmapped place
		for (int i = 0; i <= CSD_OFS_SKIPS; i += 4)
		begin
			rd(8'(i));
			chk(rdat, 32'h0);
		end
		rd(8'h14);
		chk(rsp, CSD_RESP_SLVERR);
		chk(rdat, 32'h0);
		wr(8'h14, 32'h5A);
		chk(rsp, CSD_RESP_SLVERR);
		$display("test reset and map done");
		// compares: random operands with equal and window-edge corners
		for (int i = 0; i < 40; i++)
		begin
			{w, b, f, bk} = 28'(unsigned'($random(seed)));
			{a, gt, two, ext} = 4'(unsigned'($random(seed)));
			if (i % 3 == 0) b = w;
			if (i % 4 == 1) f = (i % 8 == 1) ? 8'h5F : 8'h60;
			index_base <= 12'(unsigned'($random(seed)));
			wr(CSD_OFS_WORK, {24'h0, w});
			wr(CSD_OFS_BANK, {28'h0, bk});
			wr(CSD_OFS_CFG, {31'h0, ext});
			wr(CSD_OFS_STATUS, 32'h3);
			xa = exp_addr(f, a, ext, bk, index_base);
			i_mem.mem[xa] = b;
			hit = gt ? (b > w) : (b < w);
			skips += hit;
			issue({gt ? CSD_OPC_GT : CSD_OPC_LT, a, f}, two);
			chk(rdn, 1);
			chk(ga, xa);
			chk(sq, hit ? (two ? 8 : 4) : 0);
			rd(CSD_OFS_STATUS);
			chk(rdat, 32'h3);
		end
		rd(CSD_OFS_SKIPS);
		chk(rdat, skips);
		$display("test compare done");
		// decimal adjust across random values and flags
		for (int i = 0; i < 24; i++)
		begin
			{w, c, dcf} = 10'(unsigned'($random(seed)));
			xd = exp_adjust(w, c, dcf);
			wr(CSD_OFS_WORK, {24'hFFFFFF, w});
			wr(CSD_OFS_STATUS, {30'h0, dcf, c});
			issue(CSD_OPC_ADJ, 1'b0);
			chk(rdn, 0);
			chk(sq, 0);
			rd(CSD_OFS_WORK);
			chk(rdat, {24'h0, xd[7:0]});
			rd(CSD_OFS_STATUS);
			chk(rdat, {30'h0, dcf, xd[8]});
		end
		$display("test decimal adjust done");
		// read-only counter ignores writes
		wr(CSD_OFS_SKIPS, 32'hFF);
		chk(rsp, CSD_RESP_OKAY);
		rd(CSD_OFS_SKIPS);
		chk(rdat, skips);
		$display("test read only done");
		// clock enable low freezes the phase sequencer
		@(posedge clk);
		ce <= 1'b0;
		@(negedge clk);
		pv = phase;
		repeat (6) @(negedge clk);
		chk(phase, pv);
		@(posedge clk);
		ce <= 1'b1;
		$display("test clock enable done");
		wrap_up();
	end
endmodule
